// ==== logic/dual_timer_run_irq_square_wave_output_ctrl.v ====
// Dual 8-bit timer: run control, interrupt flags, square-wave output and AXI4-Lite registers
`timescale 1ns/100ps
`default_nettype none
`include "dual_timer_regs.vh"

module dual_timer_run_irq_square_wave_output_ctrl
(
   // Clock and reset
   input  wire                  mclk,
   input  wire                  nrst,
   // Timer input clock falling edges, one-cycle enables
   input  wire                  inClkTick0,
   input  wire                  inClkTick1,
   // AXI4-Lite write address
   input  wire                  s_axi_awvalid,
   output reg                   s_axi_awready,
   input  wire [`ADDR_W-1:0]    s_axi_awaddr,
   input  wire [2:0]            s_axi_awprot,
   // AXI4-Lite write data
   input  wire                  s_axi_wvalid,
   output reg                   s_axi_wready,
   input  wire [31:0]           s_axi_wdata,
   input  wire [3:0]            s_axi_wstrb,
   // AXI4-Lite write response
   output reg                   s_axi_bvalid,
   input  wire                  s_axi_bready,
   output reg  [1:0]            s_axi_bresp,
   // AXI4-Lite read address
   input  wire                  s_axi_arvalid,
   output reg                   s_axi_arready,
   input  wire [`ADDR_W-1:0]    s_axi_araddr,
   input  wire [2:0]            s_axi_arprot,
   // AXI4-Lite read data
   output reg                   s_axi_rvalid,
   input  wire                  s_axi_rready,
   output reg  [31:0]           s_axi_rdata,
   output reg  [1:0]            s_axi_rresp,
   // Square wave and interrupt
   output reg                   squareWaveOutput,
   output reg                   irqReq
);

   // Software registers
   reg                  chained16bitMode_r;
   reg                  squareOutChannelSelect_r;
   reg                  squareOutEnable_r;
   reg                  timer0Run_r;
   reg                  timer1Run_r;
   reg  [`CNT_W-1:0]    reload0_r;
   reg  [`CNT_W-1:0]    reload1_r;
   reg  [1:0]           irqEnable_r;
   reg  [1:0]           irqPending_r;
   reg  [1:0]           irqPending_nxt;
   reg  [3:0]           hiLatch0_r;
   reg  [`CNT_W-1:0]    latch1_r;
   reg                  square_r;
   reg                  square_nxt;
   // Bus holding registers
   reg                  awHeld_r;
   reg                  wHeld_r;
   reg  [15:0]          wrIdx_r;
   reg  [3:0]           wrNib_r;
   reg                  wrLane0_r;
   // Timer state
   wire [`CNT_W-1:0]    count0;
   wire [`CNT_W-1:0]    count1;
   wire                 running0;
   wire                 running1;
   wire                 underflow0;
   wire                 underflow1;
   wire                 tick1Sel;
   wire                 wrDo;
   wire                 rdDo;
   wire [15:0]          rdIdx;
   wire [4:0]           rdAns;
   wire                 reloadStb0;
   wire                 reloadStb1;
   wire [1:0]           pendSet;
   wire [1:0]           pendClr;
   wire                 squareSel;

   // Mapped-register check, shared by the read and write paths
   function mapped;
      input [15:0] idx;
      begin
         case (idx)
            `IDX_MODE, `IDX_OUTCTRL, `IDX_RUN0, `IDX_RUN1,
            `IDX_RLD0_LO, `IDX_RLD0_HI, `IDX_RLD1_LO, `IDX_RLD1_HI,
            `IDX_CNT0_LO, `IDX_CNT0_HI, `IDX_CNT1_LO, `IDX_CNT1_HI,
            `IDX_IRQ_EN, `IDX_IRQ_PEND:
               mapped = 1'b1;
            default:
               mapped = 1'b0;
         endcase
      end
   endfunction

   assign wrDo  = awHeld_r & wHeld_r & ~s_axi_bvalid;
   assign rdDo  = s_axi_arvalid & s_axi_arready;
   assign rdIdx = s_axi_araddr[`ADDR_W-1:2];

   // reload strobe bits act on write of one, never stored
   assign reloadStb0 = wrDo & wrLane0_r & (wrIdx_r == `IDX_RUN0) & wrNib_r[`BIT_RELOAD];
   assign reloadStb1 = wrDo & wrLane0_r & (wrIdx_r == `IDX_RUN1) & wrNib_r[`BIT_RELOAD];

   // chained mode clocks timer 1 from timer 0 underflow
   assign tick1Sel = chained16bitMode_r ? underflow0 : inClkTick1;

   // timer 0 counts while its run bit is one
   // a stopped counter holds its value
   timer_channel timer0
   (
      .mclk      (mclk),
      .nrst      (nrst),
      .tick      (inClkTick0),
      .runReq    (timer0Run_r),
      .reloadStb (reloadStb0),
      .reloadVal (reload0_r),
      .count_r   (count0),
      .running_r (running0),
      .underflow (underflow0)
   );

   // timer 1 counts while its run bit is one
   timer_channel timer1
   (
      .mclk      (mclk),
      .nrst      (nrst),
      .tick      (tick1Sel),
      .runReq    (timer1Run_r),
      .reloadStb (reloadStb1),
      .reloadVal (reload1_r),
      .count_r   (count1),
      .running_r (running1),
      .underflow (underflow1)
   );

   // underflow sets flag regardless of mask
   // timer 0 raises no flag in chained mode
   assign pendSet = {underflow1, underflow0 & ~chained16bitMode_r};
   // write one clears, write zero ignored
   assign pendClr = (wrDo && wrLane0_r && wrIdx_r == `IDX_IRQ_PEND) ? wrNib_r[1:0] : 2'h0;

   // Set wins over a clear in the same cycle so no underflow is lost
   always @*
   begin
      irqPending_nxt = (irqPending_r & ~pendClr) | pendSet;
   end

   // channel select picks the underflow source; chained mode always takes timer 1
   assign squareSel = (chained16bitMode_r | squareOutChannelSelect_r) ? underflow1 : underflow0;

   always @*
   begin
      square_nxt = square_r ^ squareSel;
   end

   // Read answer: bit 4 says mapped, low nibble is the data
   // run bit reads one until the counter has really stopped
   // count high nibbles come from the latch taken at the low read; reload high nibbles are read directly
   assign rdAns =
      (rdIdx == `IDX_MODE)     ? {1'b1, chained16bitMode_r, 3'h0} :
      (rdIdx == `IDX_OUTCTRL)  ? {1'b1, squareOutChannelSelect_r, squareOutEnable_r, 2'h0} :
      (rdIdx == `IDX_RUN0)     ? {1'b1, 3'h0, timer0Run_r | running0} :
      (rdIdx == `IDX_RUN1)     ? {1'b1, 3'h0, timer1Run_r | running1} :
      (rdIdx == `IDX_RLD0_LO)  ? {1'b1, reload0_r[3:0]} :
      (rdIdx == `IDX_RLD0_HI)  ? {1'b1, reload0_r[7:4]} :
      (rdIdx == `IDX_RLD1_LO)  ? {1'b1, reload1_r[3:0]} :
      (rdIdx == `IDX_RLD1_HI)  ? {1'b1, reload1_r[7:4]} :
      (rdIdx == `IDX_CNT0_LO)  ? {1'b1, count0[3:0]} :
      (rdIdx == `IDX_CNT0_HI)  ? {1'b1, hiLatch0_r} :
      (rdIdx == `IDX_CNT1_LO)  ? {1'b1, (chained16bitMode_r ? latch1_r[3:0] : count1[3:0])} :
      (rdIdx == `IDX_CNT1_HI)  ? {1'b1, latch1_r[7:4]} :
      (rdIdx == `IDX_IRQ_EN)   ? {1'b1, 2'h0, irqEnable_r} :
      (rdIdx == `IDX_IRQ_PEND) ? {1'b1, 2'h0, irqPending_r} :
      {mapped(rdIdx), 4'h0};

   // Bus channels: address and data taken in either order, one write at a time
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
         awHeld_r      <= 1'b0;
         wHeld_r       <= 1'b0;
         wrIdx_r       <= 16'h0000;
         wrNib_r       <= `RST_NIB;
         wrLane0_r     <= 1'b0;
      end
      else
      begin
         s_axi_awready <= ~awHeld_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
         s_axi_wready  <= ~wHeld_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            awHeld_r <= 1'b1;
            wrIdx_r  <= s_axi_awaddr[`ADDR_W-1:2];
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wHeld_r   <= 1'b1;
            wrNib_r   <= s_axi_wdata[3:0];
            wrLane0_r <= s_axi_wstrb[0];
         end
         if (wrDo)
         begin
            awHeld_r     <= 1'b0;
            wHeld_r      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(wrIdx_r) ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
         s_axi_arready <= ~s_axi_rvalid & ~rdDo;
         if (rdDo)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {28'h0000000, rdAns[3:0]};
            s_axi_rresp  <= rdAns[4] ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_rvalid && s_axi_rready)
         begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // Register writes, read latches, flags and outputs
   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         chained16bitMode_r       <= `RST_BIT;
         squareOutChannelSelect_r <= `RST_BIT;
         squareOutEnable_r        <= `RST_BIT;
         timer0Run_r              <= `RST_BIT;
         timer1Run_r              <= `RST_BIT;
         reload0_r                <= `RST_CNT;
         reload1_r                <= `RST_CNT;
         irqEnable_r              <= 2'h0;
         irqPending_r             <= 2'h0;
         hiLatch0_r               <= `RST_NIB;
         latch1_r                 <= `RST_CNT;
         square_r                 <= 1'b0;
         squareWaveOutput         <= 1'b1;
         irqReq                   <= 1'b0;
      end
      else
      begin
         if (wrDo && wrLane0_r)
         begin
            case (wrIdx_r)
               `IDX_MODE:
                  chained16bitMode_r <= wrNib_r[`BIT_CHAINED];
               `IDX_OUTCTRL:
               begin
                  squareOutChannelSelect_r <= wrNib_r[`BIT_SQUARE_OUT_CHANNEL_SELECT];
                  squareOutEnable_r        <= wrNib_r[`BIT_OUT_EN];
               end
               // request stored now, taken by the counter at its next edge
               `IDX_RUN0:
                  timer0Run_r <= wrNib_r[`BIT_RUN];
               `IDX_RUN1:
                  timer1Run_r <= wrNib_r[`BIT_RUN];
               `IDX_RLD0_LO:
                  reload0_r[3:0] <= wrNib_r;
               `IDX_RLD0_HI:
                  reload0_r[7:4] <= wrNib_r;
               `IDX_RLD1_LO:
                  reload1_r[3:0] <= wrNib_r;
               `IDX_RLD1_HI:
                  reload1_r[7:4] <= wrNib_r;
               `IDX_IRQ_EN:
                  irqEnable_r <= wrNib_r[1:0];
               default:
                  irqEnable_r <= irqEnable_r;
            endcase
         end
         // low read of timer 0 freezes the rest of the value
         if (rdDo && rdIdx == `IDX_CNT0_LO)
         begin
            hiLatch0_r <= count0[7:4];
            latch1_r   <= count1;
         end
         else if (rdDo && rdIdx == `IDX_CNT1_LO && !chained16bitMode_r)
         begin
            latch1_r <= count1;
         end
         irqPending_r <= irqPending_nxt;
         // only enabled flags reach the processor
         irqReq   <= |(irqPending_r & irqEnable_r);
         square_r <= square_nxt;
         // pin follows the wave when enabled, else sits high
         // gating is clocked here, so no half-cycle glitch appears
         squareWaveOutput <= squareOutEnable_r ? square_nxt : 1'b1;
      end
   end

endmodule
`default_nettype wire

// ==== logic/dual_timer_regs.vh ====
// Register indexes, field positions, reset values and bus codes of the dual timer
`ifndef DUAL_TIMER_REGS_VH
`define DUAL_TIMER_REGS_VH

// Register indexes; byte address is four times the index
`define IDX_MODE      16'hFFC0
`define IDX_OUTCTRL   16'hFFC1
`define IDX_RUN0      16'hFFC2
`define IDX_RUN1      16'hFFC3
`define IDX_RLD0_LO   16'hFFC4
`define IDX_RLD0_HI   16'hFFC5
`define IDX_RLD1_LO   16'hFFC6
`define IDX_RLD1_HI   16'hFFC7
`define IDX_CNT0_LO   16'hFFC8
`define IDX_CNT0_HI   16'hFFC9
`define IDX_CNT1_LO   16'hFFCA
`define IDX_CNT1_HI   16'hFFCB
`define IDX_IRQ_EN    16'hFFE2
`define IDX_IRQ_PEND  16'hFFF2

// Field positions within the 4-bit register data
`define BIT_CHAINED   3
`define BIT_SQUARE_OUT_CHANNEL_SELECT     3
`define BIT_OUT_EN    2
`define BIT_RUN       0
`define BIT_RELOAD    1
`define BIT_T0        0
`define BIT_T1        1

// Widths and reset values
`define ADDR_W        18
`define CNT_W         8
`define RST_CNT       8'h00
`define RST_BIT       1'b0
`define RST_NIB       4'h0

// Bus response codes
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// ==== logic/timer_channel.v ====
// One 8-bit down counter with run/stop synchronisation, reload and underflow
`timescale 1ns/100ps
`default_nettype none
`include "dual_timer_regs.vh"

module timer_channel
(
   // Clock and reset
   input  wire                  mclk,
   input  wire                  nrst,
   // Input clock falling edge, one-cycle enable
   input  wire                  tick,
   // Software control
   input  wire                  runReq,
   input  wire                  reloadStb,
   input  wire [`CNT_W-1:0]     reloadVal,
   // State
   output reg  [`CNT_W-1:0]     count_r,
   output reg                   running_r,
   output wire                  underflow
);

   assign underflow = tick & running_r & (count_r == `RST_CNT);

   always @(posedge mclk or negedge nrst)
   begin
      if (!nrst)
      begin
         count_r   <= `RST_CNT;
         running_r <= `RST_BIT;
      end
      else
      begin
         // software reload preset wins over counting
         if (reloadStb)
         begin
            count_r <= reloadVal;
         end
         else if (underflow)
         begin
            count_r <= reloadVal;
         end
         else if (tick && running_r)
         begin
            count_r <= count_r - 8'h01;
         end
         // run state follows request only at an input clock edge
         // no edge, no run state change
         if (tick)
         begin
            running_r <= runReq;
         end
      end
   end

endmodule
`default_nettype wire

// ==== dv/dual_timer_checker.sv ====
// Bus handshake and output timing checks for the dual timer
`timescale 1ns/100ps
`default_nettype none

module dual_timer_checker
(
   // Clock and reset
   input wire logic        mclk,
   input wire logic        nrst,
   // Timer ticks
   input wire logic        inClkTick0,
   input wire logic        inClkTick1,
   // Write channels
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp,
   // Read channels
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   // Outputs
   input wire logic        squareWaveOutput,
   input wire logic        irqReq
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write response missing");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   a_aw_held_off: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
      else $error("second write address accepted");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted while busy");
   a_rdata_nibble: assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0) else $error("upper data set");
   a_pin_cause: assert property ($changed(squareWaveOutput) |-> $past(inClkTick0) || $past(inClkTick1)
      || s_axi_bvalid || $past(s_axi_bvalid)) else $error("pin moved without cause");
   a_irq_cause: assert property ($rose(irqReq) |-> $past(inClkTick0, 2) || $past(inClkTick0, 3)
      || $past(inClkTick0, 4) || $past(inClkTick1, 2) || $past(inClkTick1, 3) || $past(s_axi_bvalid)
      || $past(s_axi_bvalid, 2)) else $error("interrupt without cause");
   a_irq_clear: assert property ($fell(irqReq) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
      else $error("interrupt fell without write");
endmodule

bind dual_timer_run_irq_square_wave_output_ctrl dual_timer_checker i_dual_timer_checker (.mclk, .nrst, .inClkTick0,
   .inClkTick1, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
   .squareWaveOutput, .irqReq);
`default_nettype wire

// ==== dv/dual_timer_run_irq_square_wave_output_ctrl_tb.sv ====
// Self-checking testbench for the dual timer block
`timescale 1ns/100ps
`default_nettype none
`include "dual_timer_regs.vh"

module dual_timer_run_irq_square_wave_output_ctrl_tb;
   // Stimulus
   logic mclk = 0, nrst = 0, inClkTick0 = 0, inClkTick1 = 0;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [`ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0;
   // Observed
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, squareWaveOutput, irqReq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int nErrors = 0, nCompared = 0;

   dual_timer_run_irq_square_wave_output_ctrl i_dual_timer_run_irq_square_wave_output_ctrl (.mclk, .nrst, .inClkTick0, .inClkTick1,
      .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_wvalid, .s_axi_wready,
      .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
      .s_axi_rresp, .squareWaveOutput, .irqReq);

   always #2 mclk = ~mclk;

   task report_and_stop;
      if (nErrors == 0 && nCompared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
      nCompared++;
      if (g !== e)
      begin
         nErrors++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask

   // Write address and data offered together; bready held until the answer
   task automatic wr(input logic [15:0] idx, input logic [3:0] d, input logic [1:0] er = `RESP_OKAY);
      bit done;
      done = 0;
      @(posedge mclk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {28'h0, d};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      // No cycle count assumed; only the watchdog ends a hung wait
      while (!done)
      begin
         @(posedge mclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
         if (s_axi_bvalid)
         begin
            s_axi_bready <= 0;
            cmp("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
            done = 1;
         end
      end
   endtask

   task automatic rd(input logic [15:0] idx, output logic [31:0] d, input logic [1:0] er = `RESP_OKAY);
      bit done;
      done = 0;
      d = 0;
      @(posedge mclk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      while (!done)
      begin
         @(posedge mclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
         if (s_axi_rvalid)
         begin
            s_axi_rready <= 0;
            d = s_axi_rdata;
            cmp("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
            done = 1;
         end
      end
   endtask

   task automatic rdCnt(input bit t, output logic [7:0] v);
      logic [31:0] lo, hi;
      rd(`IDX_CNT0_LO + 16'(2 * t), lo);
      rd(`IDX_CNT0_HI + 16'(2 * t), hi);
      v = {hi[3:0], lo[3:0]};
   endtask

   // Input clock edges, counting pin changes after each one settles
   task automatic tk(input bit t, input int n, output int tg);
      int i;
      logic p;
      tg = 0;
      for (i = 0; i < n; i++)
      begin
         // Pin sampled one edge late, so a change launched by the last write has settled
         @(posedge mclk);
         p = squareWaveOutput;
         if (t) inClkTick1 <= 1; else inClkTick0 <= 1;
         @(posedge mclk);
         inClkTick0 <= 0;
         inClkTick1 <= 0;
         repeat (6) @(posedge mclk);
         if (squareWaveOutput !== p) tg++;
      end
   endtask

   task automatic t_reset;
      logic [15:0] idxs [8] = '{`IDX_MODE, `IDX_OUTCTRL, `IDX_RUN0, `IDX_RUN1, `IDX_IRQ_EN, `IDX_IRQ_PEND,
         `IDX_CNT0_LO, `IDX_RLD1_HI};
      logic [31:0] d;
      foreach (idxs[i])
      begin
         rd(idxs[i], d);
         cmp("reset value", 32'h0, d);
      end
      cmp("pin idle", 32'h1, {31'h0, squareWaveOutput});
      rd(16'hFFD0, d, `RESP_SLVERR);
      cmp("unmapped data", 32'h0, d);
      wr(16'hFFD0, 4'hF, `RESP_SLVERR);
   endtask

   task automatic t_runstop(input bit t);
      logic [15:0] run;
      logic [31:0] d;
      logic [7:0] c, c1;
      int g;
      run = `IDX_RUN0 + 16'(t);
      wr(`IDX_RLD0_LO + 16'(2 * t), 4'h2);
      wr(`IDX_RLD0_HI + 16'(2 * t), 4'h4);
      wr(run, 4'h2);
      tk(t, 1, g);
      rdCnt(t, c);
      cmp("preset count", 32'h42, {24'h0, c});
      wr(run, 4'h1);
      rd(run, d);
      cmp("run bit", 32'h1, d);
      tk(t, 2, g);
      rdCnt(t, c1);
      tk(t, 1, g);
      rdCnt(t, c);
      cmp("count down", {24'h0, c1 - 8'h01}, {24'h0, c});
      wr(run, 4'h0);
      rd(run, d);
      cmp("stop pending", 32'h1, d);
      rd(`IDX_CNT0_LO + 16'(2 * t), d);
      tk(t, 1, g);
      rd(`IDX_CNT0_HI + 16'(2 * t), d);
      cmp("latched high", {28'h0, c[7:4]}, d);
      rdCnt(t, c);
      cmp("last decrement", {24'h0, c1 - 8'h02}, {24'h0, c});
      rd(run, d);
      cmp("stopped", 32'h0, d);
      tk(t, 3, g);
      rdCnt(t, c);
      cmp("count held", {24'h0, c1 - 8'h02}, {24'h0, c});
   endtask

   task automatic t_irq(input bit t);
      logic [31:0] d, m;
      int g;
      m = 32'h1 << t;
      wr(`IDX_RLD0_LO + 16'(2 * t), 4'h0);
      wr(`IDX_RLD0_HI + 16'(2 * t), 4'h0);
      wr(`IDX_RUN0 + 16'(t), 4'h3);
      tk(t, 4, g);
      wr(`IDX_RUN0 + 16'(t), 4'h0);
      tk(t, 1, g);
      rd(`IDX_IRQ_PEND, d);
      cmp("pending", m, d);
      cmp("masked irq", 32'h0, {31'h0, irqReq});
      wr(`IDX_IRQ_EN, m[3:0]);
      repeat (4) @(posedge mclk);
      cmp("enabled irq", 32'h1, {31'h0, irqReq});
      wr(`IDX_IRQ_PEND, 4'h0);
      rd(`IDX_IRQ_PEND, d);
      cmp("zero write", m, d);
      wr(`IDX_IRQ_PEND, m[3:0]);
      rd(`IDX_IRQ_PEND, d);
      cmp("cleared", 32'h0, d);
      cmp("irq dropped", 32'h0, {31'h0, irqReq});
      wr(`IDX_IRQ_EN, 4'h0);
   endtask

   task automatic t_square;
      logic [31:0] d;
      int g;
      wr(`IDX_RUN0, 4'h1);
      wr(`IDX_RUN1, 4'h1);
      tk(0, 2, g);
      tk(1, 2, g);
      tk(0, 3, g);
      cmp("gated toggles", 32'h0, 32'(g));
      // pin data bit kept high outside
      wr(`IDX_OUTCTRL, 4'h4);
      tk(0, 4, g);
      cmp("timer0 toggles", 32'h4, 32'(g));
      tk(1, 3, g);
      cmp("timer1 unselected", 32'h0, 32'(g));
      wr(`IDX_OUTCTRL, 4'hC);
      tk(1, 4, g);
      cmp("timer1 toggles", 32'h4, 32'(g));
      tk(0, 3, g);
      cmp("timer0 unselected", 32'h0, 32'(g));
      wr(`IDX_RLD1_LO, 4'h1);
      wr(`IDX_RUN1, 4'h3);
      wr(`IDX_MODE, 4'h8);
      wr(`IDX_OUTCTRL, 4'h4);
      tk(0, 2, g);
      tk(0, 4, g);
      cmp("chained toggles", 32'h2, 32'(g));
      tk(1, 3, g);
      cmp("chained tick1", 32'h0, 32'(g));
      wr(`IDX_IRQ_PEND, 4'h3);
      tk(0, 4, g);
      rd(`IDX_IRQ_PEND, d);
      cmp("chained pend0", 32'h0, {31'h0, d[0]});
      rd(`IDX_CNT0_LO, d);
      tk(0, 1, g);
      rd(`IDX_CNT0_HI, d);
      rd(`IDX_CNT1_LO, d);
      cmp("chained latch", 32'h1, d);
      rd(`IDX_CNT1_HI, d);
      tk(0, 1, g);
      cmp("pin low", 32'h0, {31'h0, squareWaveOutput});
      wr(`IDX_OUTCTRL, 4'h0);
      repeat (4) @(posedge mclk);
      cmp("pin high", 32'h1, {31'h0, squareWaveOutput});
   endtask

   initial
   begin
      repeat (5) @(posedge mclk);
      nrst <= 1;
      t_reset;
      t_runstop(0);
      t_runstop(1);
      t_irq(0);
      t_irq(1);
      t_square;
      report_and_stop;
   end

   // Whole run is about a thousand cycles
   initial
   begin
      #100000;
      nErrors++;
      report_and_stop;
   end
endmodule
`default_nettype wire
